// [logic/wic_pkg.sv]
// Constants, register map and mode encoding of the wake-up/interrupt block
// Function
// - Power-down ends only on an enabled pin level change and resumes normal.
// - Green mode exits on pin change or timer overflow to prior mode.
// - Power-down wake counts 2048 oscillator cycles before releasing the core.
// - Green mode wake resumes at once with no warm-up.
// - Rising or falling edge on an enabled wake pin is a trigger.
// - First port always wakes; second port pins wake only when masked in.
// - Port-1 wake mask is write-only, one bit per pin, resets zero.
// - External interrupt pin can wake from power-down into normal mode.
// - Taking an interrupt clears global enable; return sets it again.
// - Taking an interrupt pushes the stack one level and vectors to 8.
// - Enable register holds pin enable bit 0, timer enable bit 4.
// - Flag register sets pin flag bit 0, timer flag bit 4 on events.
// - Global enable is bit 7 of stack register, resets zero.
// - Pin request flag sets on a qualifying edge even when disabled.
// - Edge select bits 4:3: 01 rise, 10 fall, 11 both, reset 10.
// - Timer flag sets on every overflow in normal or green mode, whatever its enable.
// - Power-down request bit clears itself after waking.
package wic_pkg;
   // Bus geometry
   localparam int ADR_W = 10;
   localparam int DAT_W = 32;
   localparam int IDX_W = 8;
   localparam int PC_W  = 12;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_EDGE      = 8'hBF;
   localparam logic [IDX_W-1:0] IDX_WAKE_MASK = 8'hC0;
   localparam logic [IDX_W-1:0] IDX_FLAGS     = 8'hC8;
   localparam logic [IDX_W-1:0] IDX_ENABLES   = 8'hC9;
   localparam logic [IDX_W-1:0] IDX_MODE      = 8'hCA;
   localparam logic [IDX_W-1:0] IDX_STATUS    = 8'hCB;
   localparam logic [IDX_W-1:0] IDX_STACK     = 8'hDF;

   // Field positions
   localparam int EXT_BIT   = 0;
   localparam int TMR_BIT   = 4;
   localparam int GIE_BIT   = 7;
   localparam int EDGE_LO   = 3;
   localparam int EDGE_HI   = 4;
   localparam int SLEEP_BIT = 0;
   localparam int GREEN_BIT = 1;
   localparam int SLOW_BIT  = 2;

   // Reset values
   localparam logic [7:0] MASK_RESET  = 8'h00;
   localparam logic [1:0] EDGE_RESET  = 2'h2;
   localparam logic [1:0] STACK_RESET = 2'h3;

   // Edge select codes
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;

   // Interrupt entry address
   localparam logic [PC_W-1:0] VEC_ADDR = 12'h008;

   // Oscillator warm-up after power-down, in oscillator cycles
   localparam int WARM_CYCLES = 2048;
   localparam int WARM_W      = 12;

   // Operating states
   typedef enum logic [3:0] {
      st_run   = 4'h1,
      st_green = 4'h2,
      st_sleep = 4'h4,
      st_warm  = 4'h8
   } wic_state_t;
endpackage : wic_pkg

// [logic/wic_sync.sv]
// Two-stage synchroniser for asynchronous pin inputs
module wic_sync #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Data
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= '0;
         q_out  <= '0;
      end else begin
         stage1 <= d_in;
         q_out  <= stage1;
      end
   end
endmodule : wic_sync

// [logic/wic_top.sv]
// Wake-up and interrupt control with a classic Wishbone register slave
module wic_top (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   // Wishbone slave
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [wic_pkg::ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [wic_pkg::DAT_W-1:0]  wb_dat_i,
   output logic                            wb_ack_o,
   output logic      [wic_pkg::DAT_W-1:0]  wb_dat_o,
   // Wake pins and timer
   input  wire logic [7:0]                 first_port,
   input  wire logic [7:0]                 second_port,
   input  wire logic                       timer_overflow,
   // Core sequencer
   input  wire logic                       vector_taken,
   input  wire logic                       return_from_interrupt,
   output logic                            vector_request,
   output logic      [wic_pkg::PC_W-1:0]   vector_address,
   output logic                            core_run,
   output logic                            slow_mode,
   output logic                            osc_stopped
);
   import wic_pkg::*;

   wic_state_t       state;
   wic_state_t       next_state;
   logic [15:0]      pins_s;
   logic [15:0]      pins_prev;
   logic [2:0]       settle;
   logic [7:0]       port1_wake_mask;
   logic             ext_pin_irq_flag;
   logic             timer_irq_flag;
   logic             ext_pin_irq_enable;
   logic             timer_irq_enable;
   logic             global_irq_enable;
   logic [1:0]       stack_ptr;
   logic [1:0]       edge_select_field;
   logic             sleep_request_bit;
   logic             green_request;
   logic             slow_select;
   logic [7:0]       rd_byte;
   logic             next_slow;
   logic [WARM_W-1:0] warm_len;

   // Word index match, used by every register decode
   function automatic logic hit(input logic [IDX_W-1:0] a,
                                input logic [IDX_W-1:0] idx);
      return a == idx;
   endfunction : hit

   // Pin synchroniser; edges are only seen after two flops
   wic_sync #(.WIDTH(16)) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .d_in    ({second_port, first_port}),
      .q_out   (pins_s)
   );

   // Previous pin levels; edges count only once both sync stages and
   // this flop hold real levels, so a pin high at reset is no edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pins_prev <= '0;
         settle    <= '0;
      end else begin
         pins_prev <= pins_s;
         settle    <= {settle[1:0], 1'b1};
      end
   end

   // Valid from the third edge after reset
   wire prev_valid = settle[2];

   // Bus decode
   wire [IDX_W-1:0] word_idx = wb_adr_i[ADR_W-1:2];
   wire bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr_lane  = bus_req && wb_we_i && wb_sel_i[0];
   wire wr_mask  = wr_lane && hit(word_idx, IDX_WAKE_MASK);
   wire wr_flags = wr_lane && hit(word_idx, IDX_FLAGS);
   wire wr_en    = wr_lane && hit(word_idx, IDX_ENABLES);
   wire wr_stack = wr_lane && hit(word_idx, IDX_STACK);
   wire wr_edge  = wr_lane && hit(word_idx, IDX_EDGE);
   wire wr_mode  = wr_lane && hit(word_idx, IDX_MODE);
   wire [7:0] wd = wb_dat_i[7:0];

   // Pin change detection across both ports
   wire [7:0] p0_change = pins_s[7:0] ^ pins_prev[7:0];
   wire [7:0] p1_change = (pins_s[15:8] ^ pins_prev[15:8])
                          & port1_wake_mask;
   wire pin_change = prev_valid && (|p0_change || |p1_change);

   // External pin edge qualification on the first port bit
   wire ext_rise = prev_valid && pins_s[0] && !pins_prev[0];
   wire ext_fall = prev_valid && !pins_s[0] && pins_prev[0];
   wire ext_edge = (edge_select_field[0] && ext_rise)
                   || (edge_select_field[1] && ext_fall);

   // Timer is stopped while the oscillator is down
   wire tmr_event = timer_overflow
                    && (state == st_run || state == st_green);
   wire pending   = (ext_pin_irq_flag && ext_pin_irq_enable)
                    || (timer_irq_flag && timer_irq_enable);
   wire sleep_wake = (state == st_sleep) && pin_change;
   wire green_wake = (state == st_green)
                     && (pin_change || tmr_event);
   wire warm_done;

   // Warm-up counter after power-down wake
   wic_warmup #(.COUNT(WARM_CYCLES), .CW(WARM_W)) u_warm (
      .clk     (clk),
      .reset_n (reset_n),
      .start   (sleep_wake),
      .done    (warm_done)
   );

   // Mode sequencing
   always_comb begin
      next_state = state;
      case (state)
         st_run: begin
            if (sleep_request_bit) begin
               next_state = st_sleep;
            end else if (green_request) begin
               next_state = st_green;
            end
         end
         st_sleep: begin
            if (sleep_wake) begin
               next_state = st_warm;
            end
         end
         st_warm: begin
            if (warm_done) begin
               next_state = st_run;
            end
         end
         st_green: begin
            if (green_wake) begin
               next_state = st_run;
            end
         end
         default: begin
            next_state = st_run;
         end
      endcase
   end

   // Power-down wake always lands in normal speed
   assign next_slow = sleep_wake ? 1'b0
                    : (wr_mode ? wd[SLOW_BIT] : slow_select);

   // State and mode control bits
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state             <= st_run;
         sleep_request_bit <= 1'b0;
         green_request     <= 1'b0;
         slow_select       <= 1'b0;
      end else begin
         state       <= next_state;
         slow_select <= next_slow;
         if (sleep_wake) begin
            sleep_request_bit <= 1'b0;
         end else if (wr_mode) begin
            sleep_request_bit <= wd[SLEEP_BIT];
         end
         if (green_wake) begin
            green_request <= 1'b0;
         end else if (wr_mode) begin
            green_request <= wd[GREEN_BIT];
         end
      end
   end

   // Software registers; hardware events win over software writes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port1_wake_mask    <= MASK_RESET;
         edge_select_field  <= EDGE_RESET;
         ext_pin_irq_enable <= 1'b0;
         timer_irq_enable   <= 1'b0;
         ext_pin_irq_flag   <= 1'b0;
         timer_irq_flag     <= 1'b0;
      end else begin
         if (wr_mask) port1_wake_mask <= wd;
         if (wr_edge) edge_select_field <= wd[EDGE_HI:EDGE_LO];
         if (wr_en) begin
            ext_pin_irq_enable <= wd[EXT_BIT];
            timer_irq_enable   <= wd[TMR_BIT];
         end
         ext_pin_irq_flag <= ext_edge
            || (wr_flags ? wd[EXT_BIT] : ext_pin_irq_flag);
         timer_irq_flag <= tmr_event
            || (wr_flags ? wd[TMR_BIT] : timer_irq_flag);
      end
   end

   // Global enable and stack level follow the core's entry and return
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         global_irq_enable <= 1'b0;
         stack_ptr         <= STACK_RESET;
      end else if (vector_taken) begin
         global_irq_enable <= 1'b0;
         stack_ptr         <= stack_ptr + 2'h1;
      end else if (return_from_interrupt) begin
         global_irq_enable <= 1'b1;
         stack_ptr         <= stack_ptr - 2'h1;
      end else if (wr_stack) begin
         global_irq_enable <= wd[GIE_BIT];
         stack_ptr         <= wd[1:0];
      end
   end

   // Read mux; the wake mask is write-only and reads zero
   always_comb begin
      rd_byte = 8'h00;
      if (hit(word_idx, IDX_FLAGS)) begin
         rd_byte[EXT_BIT] = ext_pin_irq_flag;
         rd_byte[TMR_BIT] = timer_irq_flag;
      end else if (hit(word_idx, IDX_ENABLES)) begin
         rd_byte[EXT_BIT] = ext_pin_irq_enable;
         rd_byte[TMR_BIT] = timer_irq_enable;
      end else if (hit(word_idx, IDX_STACK)) begin
         rd_byte[GIE_BIT] = global_irq_enable;
         rd_byte[1:0]     = stack_ptr;
      end else if (hit(word_idx, IDX_EDGE)) begin
         rd_byte[EDGE_HI:EDGE_LO] = edge_select_field;
      end else if (hit(word_idx, IDX_MODE)) begin
         rd_byte[SLEEP_BIT] = sleep_request_bit;
         rd_byte[GREEN_BIT] = green_request;
         rd_byte[SLOW_BIT]  = slow_select;
      end else if (hit(word_idx, IDX_STATUS)) begin
         rd_byte[3:0] = state;
      end
   end

   // Bus answer: one-cycle ack, unmapped reads return zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) wb_dat_o <= {24'h000000, rd_byte};
      end
   end

   // Core-facing outputs, all registered
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         vector_request <= 1'b0;
         vector_address <= VEC_ADDR;
         core_run       <= 1'b1;
         slow_mode      <= 1'b0;
         osc_stopped    <= 1'b0;
      end else begin
         vector_request <= (state == st_run) && global_irq_enable
                           && pending && !vector_taken;
         vector_address <= VEC_ADDR;
         core_run       <= (next_state == st_run);
         slow_mode      <= next_slow;
         osc_stopped    <= (next_state == st_sleep);
      end
   end

   // Warm-up length observer for checking
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         warm_len <= '0;
      end else if (state == st_warm) begin
         warm_len <= warm_len + 1'b1;
      end else begin
         warm_len <= '0;
      end
   end

   localparam logic [WARM_W-1:0] WARM_LAST = WARM_W'(WARM_CYCLES - 1);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   vec_gated_a: assert property (
      vector_request |-> $past(global_irq_enable) && $past(pending))
      else $error("vector request without enabled pending source");

   gie_entry_a: assert property (
      vector_taken |=> !global_irq_enable && !vector_request)
      else $error("global enable not cleared on interrupt entry");

   gie_return_a: assert property (
      return_from_interrupt && !vector_taken |=> global_irq_enable)
      else $error("global enable not restored on return");

   stack_push_a: assert property (
      vector_taken |=> stack_ptr == $past(stack_ptr) + 2'h1)
      else $error("stack not pushed on interrupt entry");

   warm_length_a: assert property (
      state == st_warm && next_state == st_run |-> warm_len == WARM_LAST)
      else $error("warm-up length wrong");

   sleep_exit_a: assert property (
      state == st_sleep && !pin_change |=> state == st_sleep)
      else $error("power-down left without a pin change");

   sleep_clear_a: assert property (
      sleep_wake |=> !sleep_request_bit && state == st_warm && !slow_select)
      else $error("power-down wake did not clear request");

   green_exit_a: assert property (
      green_wake |=> core_run && slow_mode == $past(slow_select))
      else $error("green wake not immediate or mode lost");

   timer_flag_a: assert property (
      tmr_event |=> timer_irq_flag)
      else $error("timer flag not set on overflow");

   ext_flag_a: assert property (
      ext_edge |=> ext_pin_irq_flag)
      else $error("pin flag not set on qualifying edge");
endmodule : wic_top

// [logic/wic_warmup.sv]
// Warm-up counter holding the core after a power-down wake
module wic_warmup #(
   parameter int COUNT = 2048,
   parameter int CW    = 12
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Control
   input  wire logic start,
   output logic      done
);
   logic [CW-1:0] cnt;
   logic          busy;
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

   // Last counted cycle
   assign done = busy && (cnt == LAST);

   // Count from start until the last cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt  <= '0;
         busy <= 1'b0;
      end else if (start) begin
         cnt  <= '0;
         busy <= 1'b1;
      end else if (busy) begin
         cnt  <= cnt + 1'b1;
         busy <= !done;
      end
   end
endmodule : wic_warmup

// [verif/tb_wic_top.sv]
// Register-level testbench of the wake-up and interrupt block
module tb_wic_top;
   timeunit 1ns;
   timeprecision 100ps;
   import wic_pkg::*;
   logic             clk = 1'b0;
   logic             reset_n = 1'b0;
   logic             cyc = 1'b0;
   logic             stb = 1'b0;
   logic             we = 1'b0;
   logic [ADR_W-1:0] adr = '0;
   logic [3:0]       sel = 4'h0;
   logic [DAT_W-1:0] wdat = '0;
   logic [7:0]       p0 = 8'h00;
   logic [7:0]       p1 = 8'h00;
   logic             tov = 1'b0;
   logic             ret_go = 1'b0;
   logic [3:0]       dly = 4'h0;
   logic             ack, vtk, rfi, vreq, crun, slow, ostop;
   logic [DAT_W-1:0] rdat;
   logic [PC_W-1:0]  vaddr;
   logic [7:0]       tcnt, rd;
   int               miscompares = 0;
   int               compares = 0;
   int               n;

   // 250 MHz system clock
   always #2 clk = ~clk;

   wic_top u_wic_top (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .first_port(p0),
      .second_port(p1), .timer_overflow(tov), .vector_taken(vtk),
      .return_from_interrupt(rfi), .vector_request(vreq),
      .vector_address(vaddr), .core_run(crun), .slow_mode(slow),
      .osc_stopped(ostop));

   wic_core_model u_wic_core_model (.clk(clk), .reset_n(reset_n),
      .take_delay(dly), .return_go(ret_go), .vector_request(vreq),
      .vector_taken(vtk), .return_from_interrupt(rfi), .taken_count(tcnt));

   task automatic summarize();
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   task automatic chk_reg(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_reg

   task automatic chk_cnt(input string nm, input int e, input int g);
      compares++;
      if (g != e) begin
         miscompares++;
         $display("mismatch %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_cnt

   // Classic single cycle; request held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
      int k;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      sel  <= 4'hF;
      adr  <= {idx, 2'h0};
      wdat <= {24'h000000, d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 64);
      if (k >= 64)
         miscompares++;
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] idx,
                      input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      chk_reg(nm, e, rd);
   endtask : rdc

   // Pin toggle; the synchroniser needs two edges before it is seen
   task automatic pin(input logic [7:0] m0, input logic [7:0] m1);
      @(posedge clk);
      p0 <= p0 ^ m0;
      p1 <= p1 ^ m1;
      repeat (6) @(posedge clk);
   endtask : pin

   task automatic tick();
      @(posedge clk);
      tov <= 1'b1;
      @(posedge clk);
      tov <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : tick

   // Wake from power-down and count the cycles the core is held
   task automatic wake(input logic [7:0] m0, input logic [7:0] m1);
      @(posedge clk);
      p0 <= p0 ^ m0;
      p1 <= p1 ^ m1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ostop === 1'b1 && n < 20);
      n = 0;
      while (crun !== 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      chk_cnt("warm_cycles", WARM_CYCLES, n);
      rdc("mode", IDX_MODE, 8'h00);
      chk_reg("slow_mode", 8'h00, {7'h00, slow});
   endtask : wake

   // Watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      summarize();
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      chk_reg("vector_address", 8'h08, vaddr[7:0]);
      rdc("edge_select", IDX_EDGE, 8'h10);
      rdc("port1_wake_mask", IDX_WAKE_MASK, 8'h00);
      rdc("interrupt_flags", IDX_FLAGS, 8'h00);
      rdc("interrupt_enables", IDX_ENABLES, 8'h00);
      rdc("stack_and_global_enable", IDX_STACK, 8'h03);
      wr(IDX_ENABLES, 8'hFF);
      rdc("interrupt_enables", IDX_ENABLES, 8'h11);
      wr(IDX_ENABLES, 8'h00);
      wr(IDX_WAKE_MASK, 8'hFF);
      rdc("port1_wake_mask", IDX_WAKE_MASK, 8'h00);
      wr(IDX_WAKE_MASK, 8'h00);
      wr(8'h10, 8'hFF);
      rdc("unmapped", 8'h10, 8'h00);
      tick();
      rdc("interrupt_flags", IDX_FLAGS, 8'h10);
      chk_reg("vector_request", 8'h00, {7'h00, vreq});
      wr(IDX_FLAGS, 8'h00);
      rdc("interrupt_flags", IDX_FLAGS, 8'h00);
      // Every edge code: rising toggle first, then falling
      for (int e = 0; e < 4; e++) begin
         wr(IDX_EDGE, {3'h0, e[1:0], 3'h0});
         wr(IDX_FLAGS, 8'h00);
         pin(8'h01, 8'h00);
         rdc("rise_flag", IDX_FLAGS, {7'h00, e[0]});
         wr(IDX_FLAGS, 8'h00);
         pin(8'h01, 8'h00);
         rdc("fall_flag", IDX_FLAGS, {7'h00, e[1]});
      end
      wr(IDX_ENABLES, 8'h01);
      pin(8'h01, 8'h00);
      chk_reg("vector_request", 8'h00, {7'h00, vreq});
      // Prompt and slow core answers
      for (int d = 0; d < 2; d++) begin
         dly <= d[0] ? 4'h5 : 4'h0;
         wr(IDX_STACK, 8'h01);
         pin(8'h01, 8'h00);
         wr(IDX_STACK, 8'h81);
         n = 0;
         while (tcnt !== 8'(d + 1) && n < 50) begin
            @(posedge clk);
            n++;
         end
         chk_cnt("vectors_taken", d + 1, int'(tcnt));
         rdc("stack_and_global_enable", IDX_STACK, 8'h02);
         chk_reg("vector_request", 8'h00, {7'h00, vreq});
         wr(IDX_FLAGS, 8'h00);
         @(posedge clk);
         ret_go <= 1'b1;
         @(posedge clk);
         ret_go <= 1'b0;
         repeat (2) @(posedge clk);
         rdc("stack_and_global_enable", IDX_STACK, 8'h81);
      end
      wr(IDX_STACK, 8'h03);
      wr(IDX_ENABLES, 8'h00);
      // Power-down: timer and unmasked second port must not wake
      wr(IDX_MODE, 8'h05);
      rdc("status", IDX_STATUS, 8'h04);
      chk_reg("osc_stopped", 8'h01, {7'h00, ostop});
      tick();
      pin(8'h00, 8'h01);
      rdc("status", IDX_STATUS, 8'h04);
      wr(IDX_WAKE_MASK, 8'h01);
      wake(8'h00, 8'h01);
      wr(IDX_FLAGS, 8'h00);
      wr(IDX_MODE, 8'h01);
      wake(8'h01, 8'h00);
      rdc("interrupt_flags", IDX_FLAGS, 8'h01);
      // Green mode from slow: timer, then masked second port
      for (int t = 0; t < 2; t++) begin
         wr(IDX_MODE, 8'h04);
         wr(IDX_MODE, 8'h06);
         rdc("status", IDX_STATUS, 8'h02);
         chk_reg("core_run", 8'h00, {7'h00, crun});
         if (t == 0)
            tick();
         else
            pin(8'h00, 8'h01);
         rdc("status", IDX_STATUS, 8'h01);
         chk_reg("slow_mode", 8'h01, {7'h00, slow});
         rdc("mode", IDX_MODE, 8'h04);
      end
      summarize();
   end
endmodule : tb_wic_top

// [verif/wic_core_model.sv]
// Core sequencer model facing the interrupt handshake
module wic_core_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Bench controls
   input  wire logic [3:0] take_delay,
   input  wire logic       return_go,
   // Core handshake
   input  wire logic       vector_request,
   output logic            vector_taken,
   output logic            return_from_interrupt,
   output logic      [7:0] taken_count
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] wait_cnt;
   logic       hold;

   // Take each request once, after a delay; hold blocks a second take
   // while the request level is still falling
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         vector_taken          <= 1'b0;
         return_from_interrupt <= 1'b0;
         taken_count           <= 8'h00;
         wait_cnt              <= 4'h0;
         hold                  <= 1'b0;
      end else begin
         vector_taken          <= 1'b0;
         return_from_interrupt <= return_go;
         if (!vector_request) begin
            hold     <= 1'b0;
            wait_cnt <= 4'h0;
         end else if (!hold) begin
            if (wait_cnt == take_delay) begin
               vector_taken <= 1'b1;
               hold         <= 1'b1;
               taken_count  <= taken_count + 8'h01;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end
      end
   end
endmodule : wic_core_model
